/* common/acsq_pkg.sv */
package acsq_pkg;
  // register word indices, byte address is four times the index
  localparam logic [3:0] REG_CTL_TWO = 4'h0;
  localparam logic [3:0] REG_CTL_THREE = 4'h1;
  localparam logic [3:0] REG_CTL_FOUR = 4'h2;
  localparam logic [3:0] REG_CTL_FIVE = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_TEST = 4'h5;
  localparam logic [3:0] REG_DIG_IN = 4'h6;
  localparam logic [3:0] REG_DIG_EN = 4'h7;
  localparam logic [3:0] REG_RESULT_BASE = 4'h8;
  localparam int NUM_REGS = 16;
  localparam int NUM_CHANNELS = 8;
  // control two fields
  localparam int BIT_POWER_UP = 7;
  localparam int BIT_HALT_IN_WAIT = 2;
  localparam int BIT_SEQ_IRQ_EN = 1;
  // control three fields
  localparam int BIT_LEN_EIGHT = 3;
  // control four fields
  localparam int BIT_RES_TEN = 7;
  localparam int SMP_LSB = 5;
  localparam int PRS_LSB = 0;
  // control five fields
  localparam int BIT_RIGHT_JUST = 7;
  localparam int BIT_SPECIAL = 6;
  localparam int BIT_SCAN = 5;
  localparam int BIT_MULTI = 4;
  localparam int BIT_LEN_ONE = 3;
  localparam int CC_LSB = 0;
  // status fields
  localparam int BIT_SEQ_FLAG = 15;
  localparam int BIT_BUSY = 14;
  // test fields
  localparam int BIT_SOFT_RESET = 0;
  // reset values
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_DIG_EN = 8'h00;
  // sampling and conversion timing in module clocks
  localparam logic [4:0] SMP_FIXED_CLKS = 5'h06;
  localparam logic [4:0] SMP_VAR_BASE = 5'h02;
  localparam logic [3:0] CNV_SETUP_CLKS = 4'h2;
  localparam logic [3:0] CNV_CLKS_EIGHT = 4'ha;
  localparam logic [3:0] CNV_CLKS_TEN = 4'hc;
  // special conversion reference selection
  localparam logic [1:0] SPC_NONE = 2'h0;
  localparam logic [1:0] SPC_LOW = 2'h1;
  localparam logic [1:0] SPC_HIGH = 2'h2;
  localparam logic [1:0] SPC_MID = 2'h3;

  typedef enum logic [1:0] {
    SQ_IDLE = 2'b00,
    SQ_START = 2'b01,
    SQ_WAIT = 2'b11
  } acsq_seq_t;

  typedef enum logic [1:0] {
    SR_IDLE = 2'b00,
    SR_SAMPLE = 2'b01,
    SR_CONVERT = 2'b11
  } acsq_sar_st_t;

  // analog front end controls
  typedef struct packed {
    logic [2:0] channel;
    logic [1:0] special;
    logic sample_en;
    logic [9:0] dac_code;
  } acsq_analog_t;

  typedef struct packed {
    acsq_sar_st_t st;
    logic [4:0] cnt;
    logic [9:0] sar;
    logic [9:0] mask;
    logic [9:0] result;
    logic done;
  } acsq_sar_state_t;

  typedef struct packed {
    logic [7:0] ctl_two;
    logic [7:0] ctl_three;
    logic [7:0] ctl_four;
    logic [7:0] ctl_five;
    logic seq_flag;
    logic [7:0] loaded;
    logic [7:0] dig_en;
    logic [7:0][15:0] results;
    acsq_seq_t seq;
    logic [2:0] idx;
    logic [4:0] prs_cnt;
    logic prs_half;
    logic ce;
    logic ack;
    logic [31:0] rdata;
  } acsq_state_t;
endpackage

/* src/acsq_sar.sv */
`timescale 1ns/10ps
`default_nettype none
module acsq_sar
  import acsq_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // control from the sequencer
  input wire logic ce_in,
  input wire logic start_in,
  input wire logic abort_in,
  input wire logic res_ten_in,
  input wire logic [1:0] smp_sel_in,
  // analog comparator
  input wire logic comp_in,
  // results
  output logic sample_en_out,
  output logic [9:0] dac_code_out,
  output logic [9:0] result_out,
  output logic done_out
);
  acsq_sar_state_t s_ff, nxt_s;
  logic [4:0] smp_last;
  logic [4:0] cnv_last;

  // sample and conversion lengths in module clocks
  assign smp_last = SMP_FIXED_CLKS + (SMP_VAR_BASE << smp_sel_in) - 5'h01;
  assign cnv_last = {1'b0, (res_ten_in ? CNV_CLKS_TEN : CNV_CLKS_EIGHT)} - 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // sample then binary search
  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    if (abort_in) begin
      nxt_s.st = SR_IDLE;
    end else if (start_in) begin
      nxt_s.st = SR_SAMPLE;
      nxt_s.cnt = 5'h00;
      nxt_s.sar = 10'h000;
      // both widths search from the full-scale top bit, eight bits stop two early
      nxt_s.mask = 10'h200;
    end else if (ce_in) begin
      unique case (s_ff.st)
        SR_IDLE: begin
        end
        SR_SAMPLE: begin
          if (s_ff.cnt == smp_last) begin
            nxt_s.st = SR_CONVERT;
            nxt_s.cnt = 5'h00;
          end else begin
            nxt_s.cnt = s_ff.cnt + 5'h01;
          end
        end
        SR_CONVERT: begin
          nxt_s.cnt = s_ff.cnt + 5'h01;
          if (s_ff.cnt >= {1'b0, CNV_SETUP_CLKS} && s_ff.mask != 10'h000) begin
            if (comp_in) begin
              nxt_s.sar = s_ff.sar | s_ff.mask;
            end
            nxt_s.mask = s_ff.mask >> 1;
          end
          if (s_ff.cnt == cnv_last) begin
            nxt_s.st = SR_IDLE;
            // last decision included, eight-bit results right aligned
            nxt_s.result = res_ten_in ? nxt_s.sar : {2'b00, nxt_s.sar[9:2]};
            nxt_s.done = 1'b1;
          end
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sample_en_out = (s_ff.st == SR_SAMPLE);
  assign dac_code_out = s_ff.sar | s_ff.mask;
  assign result_out = s_ff.result;
  assign done_out = s_ff.done;
endmodule
`default_nettype wire

/* src/acsq_top.sv */
// How it works
// - eight channels feed one successive approximation core of 8 or 10 bits
// - length bits in control three and five give 1, 4 or 8 conversions
// - multi clear converts one channel, multi set steps through channels
// - scan set restarts after each sequence, clear stops after one
// - special mode converts low reference, high reference or midpoint
// - three-bit code in control five picks channel or first of group
// - two-bit field in control four picks the sampling length
// - writing control four or five starts a new sequence or halts
// - a new non-continuous sequence ends continuous running when done
// - power down, reset, stop, or wait with halt enabled stop sequencing
// - sequence complete flag sets at the end of each sequence
// - each result register has a flag set when it is loaded
// - a sequence complete interrupt can be raised, or flags polled
// - results stored left or right justified by software choice
// - sixteen register words for control, test and configuration
// - second unit comes out of reset disabled with input-only pins
// - each input pin serves as analog channel or digital input
// - power-up bit resets low and power down aborts the sequence
// - conversion takes 10 or 12 module clocks, then result is stored
`timescale 1ns/10ps
`default_nettype none
module acsq_top
  import acsq_pkg::*;
#(
  parameter int UNIT_INDEX = 0
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // avalon-mm slave
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // system power modes
  input wire logic stop_in,
  input wire logic wait_in,
  // pins and analog front end
  input wire logic [7:0] pin_in,
  input wire logic comp_in,
  output acsq_analog_t analog_out,
  // interrupt
  output logic seq_irq_out
);
  logic [1:0] rst_sync_ff;
  logic rst_n;
  acsq_state_t s_ff, nxt_s;
  logic req, acc, wr_acc, rd_acc;
  logic [3:0] widx;
  logic [15:0] wmask, wval;
  logic halt, soft_rst, power_up;
  logic halt_pdown, halt_stop, halt_wait;
  logic start_wr, seq_end, busy, res_ten;
  logic [1:0] spc_sel;
  logic [7:0] dig_in_val;
  logic [3:0] seq_last;
  logic [2:0] chan;
  logic sar_start, sar_abort, sar_done, sar_smp;
  logic [9:0] sar_result, sar_dac;
  logic [15:0] just_val;
  logic [15:0] rd_word;
  logic [15:0] status_word;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  ////////////////////////////////////////////////////////////////////////////
  // bus decode, one wait cycle per access
  assign req = avs_read_in | avs_write_in;
  assign acc = req & s_ff.ack;
  assign wr_acc = acc & avs_write_in;
  assign rd_acc = req & ~s_ff.ack & avs_read_in;
  assign widx = avs_address_in[5:2];
  assign wmask = {{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
  assign wval = avs_writedata_in[15:0];

  // power and halt conditions
  assign power_up = s_ff.ctl_two[BIT_POWER_UP];
  assign soft_rst = wr_acc && widx == REG_TEST && wmask[BIT_SOFT_RESET] && wval[BIT_SOFT_RESET];

  // halt sources kept apart so the cause of an abort is easy to trace
  assign halt_pdown = ~power_up;
  assign halt_stop = stop_in;
  assign halt_wait = wait_in & s_ff.ctl_two[BIT_HALT_IN_WAIT];
  assign halt = halt_pdown | halt_stop | halt_wait | soft_rst;

  // an accepted write to control four or five restarts the sequence
  assign start_wr = wr_acc && (widx == REG_CTL_FOUR || widx == REG_CTL_FIVE);

  // sequence length and channel selection
  always_comb begin
    if (s_ff.ctl_three[BIT_LEN_EIGHT]) begin
      seq_last = 4'h7;
    end else if (s_ff.ctl_five[BIT_LEN_ONE]) begin
      seq_last = 4'h0;
    end else begin
      seq_last = 4'h3;
    end
  end

  // converted channel, fixed or stepping through a group
  always_comb begin
    if (!s_ff.ctl_five[BIT_MULTI]) begin
      chan = s_ff.ctl_five[CC_LSB +: 3];
    end else if (seq_last == 4'h7) begin
      chan = s_ff.ctl_five[CC_LSB +: 3] + s_ff.idx;
    end else begin
      chan = {s_ff.ctl_five[CC_LSB + 2], s_ff.ctl_five[CC_LSB +: 2] + s_ff.idx[1:0]};
    end
  end

  // resolution choice, ten bits when set
  assign res_ten = s_ff.ctl_four[BIT_RES_TEN];

  // justification of the new result
  always_comb begin
    if (res_ten) begin
      just_val = s_ff.ctl_five[BIT_RIGHT_JUST] ? {6'h00, sar_result} : {sar_result, 6'h00};
    end else begin
      just_val = s_ff.ctl_five[BIT_RIGHT_JUST] ? {8'h00, sar_result[7:0]} : {sar_result[7:0], 8'h00};
    end
  end

  // sequencer running, seen by software as the busy bit
  assign busy = (s_ff.seq != SQ_IDLE);

  // pins with their digital enable bit set read back as zero
  assign dig_in_val = pin_in & ~s_ff.dig_en;

  // read mux
  assign status_word = {s_ff.seq_flag, busy, 6'h00, s_ff.loaded};
  always_comb begin
    rd_word = 16'h0000;
    if (widx >= REG_RESULT_BASE) begin
      rd_word = s_ff.results[widx[2:0]];
    end else begin
      unique case (widx)
        REG_CTL_TWO: rd_word = {8'h00, s_ff.ctl_two};
        REG_CTL_THREE: rd_word = {8'h00, s_ff.ctl_three};
        REG_CTL_FOUR: rd_word = {8'h00, s_ff.ctl_four};
        REG_CTL_FIVE: rd_word = {8'h00, s_ff.ctl_five};
        REG_STATUS: rd_word = status_word;
        REG_TEST: rd_word = 16'h0000;
        REG_DIG_IN: rd_word = {8'h00, dig_in_val};
        REG_DIG_EN: rd_word = {8'h00, s_ff.dig_en};
        default: rd_word = 16'h0000;
      endcase
    end
  end

  assign sar_start = (s_ff.seq == SQ_START) & ~halt;
  assign sar_abort = halt | (s_ff.seq == SQ_IDLE);

  // last conversion of the sequence has just delivered its result
  assign seq_end = (s_ff.seq == SQ_WAIT) && sar_done && ({1'b0, s_ff.idx} == seq_last);

  // byte lane merge for the eight-bit registers
  function automatic logic [7:0] lane_merge(input logic [7:0] old_v, input logic [7:0] new_v, input logic [7:0] m);
    return (old_v & ~m) | (new_v & m);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state of registers, prescaler and sequencer
  always_comb begin
    nxt_s = s_ff;
    // ack follows request by one cycle, giving each access one wait state
    nxt_s.ack = req & ~s_ff.ack;
    // read data captured in the first cycle of a read
    if (rd_acc) begin
      nxt_s.rdata = {16'h0000, rd_word};
    end
    // module clock enable: bus clock over (prescale + 1) over two
    nxt_s.ce = 1'b0;
    if (!power_up) begin
      nxt_s.prs_cnt = 5'h00;
      nxt_s.prs_half = 1'b0;
    end else if (s_ff.prs_cnt == 5'h00) begin
      nxt_s.prs_cnt = s_ff.ctl_four[PRS_LSB +: 5];
      nxt_s.prs_half = ~s_ff.prs_half;
      nxt_s.ce = s_ff.prs_half;
    end else begin
      nxt_s.prs_cnt = s_ff.prs_cnt - 5'h01;
    end
    // register writes
    if (wr_acc) begin
      unique case (widx)
        REG_CTL_TWO: nxt_s.ctl_two = lane_merge(s_ff.ctl_two, wval[7:0], wmask[7:0]);
        REG_CTL_THREE: nxt_s.ctl_three = lane_merge(s_ff.ctl_three, wval[7:0], wmask[7:0]);
        REG_CTL_FOUR: nxt_s.ctl_four = lane_merge(s_ff.ctl_four, wval[7:0], wmask[7:0]);
        REG_CTL_FIVE: nxt_s.ctl_five = lane_merge(s_ff.ctl_five, wval[7:0], wmask[7:0]);
        REG_STATUS: begin
          nxt_s.seq_flag = s_ff.seq_flag & ~(wmask[BIT_SEQ_FLAG] & wval[BIT_SEQ_FLAG]);
          nxt_s.loaded = s_ff.loaded & ~(wmask[7:0] & wval[7:0]);
        end
        REG_DIG_EN: nxt_s.dig_en = lane_merge(s_ff.dig_en, wval[7:0], wmask[7:0]);
        default: begin
        end
      endcase
    end
    // sequencer
    if (halt) begin
      nxt_s.seq = SQ_IDLE;
    end else if (start_wr) begin
      nxt_s.seq = SQ_START;
      nxt_s.idx = 3'h0;
      nxt_s.seq_flag = 1'b0;
      nxt_s.loaded = 8'h00;
    end else begin
      unique case (s_ff.seq)
        SQ_IDLE: begin
        end
        SQ_START: nxt_s.seq = SQ_WAIT;
        SQ_WAIT: begin
          if (sar_done) begin
            // results land in order from the first result register
            nxt_s.results[s_ff.idx] = just_val;
            nxt_s.loaded[s_ff.idx] = 1'b1;
            if (seq_end) begin
              nxt_s.seq_flag = 1'b1;
              nxt_s.idx = 3'h0;
              nxt_s.seq = s_ff.ctl_five[BIT_SCAN] ? SQ_START : SQ_IDLE;
            end else begin
              nxt_s.idx = s_ff.idx + 3'h1;
              nxt_s.seq = SQ_START;
            end
          end
        end
      endcase
    end
    // soft reset clears all but the power-up bit
    if (soft_rst) begin
      nxt_s = '0;
      nxt_s.ctl_two = RST_CTL;
      nxt_s.ctl_two[BIT_POWER_UP] = power_up;
      nxt_s.ack = 1'b0;
    end
  end

  // state register, powered down after reset
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sample and conversion engine
  acsq_sar u_sar (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .ce_in(s_ff.ce),
    .start_in(sar_start),
    .abort_in(sar_abort),
    .res_ten_in(res_ten),
    .smp_sel_in(s_ff.ctl_four[SMP_LSB +: 2]),
    .comp_in(comp_in),
    .sample_en_out(sar_smp),
    .dac_code_out(sar_dac),
    .result_out(sar_result),
    .done_out(sar_done)
  );

  // reference choice in special mode, code bit one picks the midpoint
  always_comb begin
    if (!s_ff.ctl_five[BIT_SPECIAL]) begin
      spc_sel = SPC_NONE;
    end else if (s_ff.ctl_five[CC_LSB + 1]) begin
      spc_sel = SPC_MID;
    end else if (s_ff.ctl_five[CC_LSB]) begin
      spc_sel = SPC_HIGH;
    end else begin
      spc_sel = SPC_LOW;
    end
  end

  // bus side outputs
  assign avs_readdata_out = s_ff.rdata;
  assign avs_waitrequest_out = req & ~s_ff.ack;

  // analog front end controls
  assign analog_out.channel = chan;
  assign analog_out.special = spc_sel;
  assign analog_out.sample_en = sar_smp;
  assign analog_out.dac_code = sar_dac;

  // interrupt request level
  assign seq_irq_out = s_ff.seq_flag & s_ff.ctl_two[BIT_SEQ_IRQ_EN];
endmodule
`default_nettype wire

/* sim/acsq_chk.sv */
`timescale 1ns/10ps
`default_nettype none
module acsq_chk
  import acsq_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic arst_n_in,
  // register bus
  input wire logic [5:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [3:0] avs_byteenable_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  // power modes and front end
  input wire logic stop_in,
  input wire acsq_analog_t analog_out,
  input wire logic seq_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // accepted writes and their target word
  wire req = avs_read_in || avs_write_in;
  wire acc = avs_write_in && !avs_waitrequest_out;
  wire [3:0] idx = avs_address_in[5:2];
  wire ctl2 = acc && idx == REG_CTL_TWO && avs_byteenable_in[0];
  //////////////////////////////////////////////////////////////////////
  a_wait_first: assert property ($rose(req) |-> avs_waitrequest_out)
    else $error("no wait state in first access cycle");
  a_ack_next: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("access not answered in second cycle");
  a_idle_nowait: assert property (!req |-> !avs_waitrequest_out)
    else $error("wait state without request");
  a_upper_zero: assert property (avs_readdata_out[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_rdata_hold: assert property (!avs_read_in && !(acc && idx == REG_TEST) |=> $stable(avs_readdata_out))
    else $error("read data moved without a read");
  a_irq_off: assert property (ctl2 && !avs_writedata_in[BIT_SEQ_IRQ_EN] |=> !seq_irq_out)
    else $error("interrupt stays with enable cleared");
  a_irq_fall: assert property ($fell(seq_irq_out) |-> $past(acc))
    else $error("completion flag dropped without a write");
  a_pdown_quiet: assert property (ctl2 && !avs_writedata_in[BIT_POWER_UP] |=> ##1 !analog_out.sample_en [*4])
    else $error("sampling after power down");
  a_stop_quiet: assert property (stop_in [*3] |-> !analog_out.sample_en)
    else $error("sampling during stop");
  a_out_reset: assert property ($rose(arst_n_in) |-> analog_out == '0 && !seq_irq_out)
    else $error("outputs not cleared by reset");
  // main scenarios
  c_sample: cover property ($rose(analog_out.sample_en));
  c_irq: cover property ($rose(seq_irq_out));
  c_stop: cover property (stop_in && analog_out.sample_en);
endmodule
bind acsq_top acsq_chk u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
  .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out), .stop_in(stop_in), .analog_out(analog_out),
  .seq_irq_out(seq_irq_out));
`default_nettype wire

/* sim/acsq_analog_model.sv */
`timescale 1ns/10ps
`default_nettype none
module acsq_analog_model
  import acsq_pkg::*;
(
  // front end controls
  input wire acsq_analog_t analog_in,
  // comparator
  output logic comp_out
);
  logic [9:0] lvl;
  logic [9:0] held = 10'h155;
  // pin level per channel, references in special mode
  always_comb begin
    case (analog_in.special)
      SPC_LOW: lvl = 10'h000;
      SPC_HIGH: lvl = 10'h3ff;
      SPC_MID: lvl = 10'h200;
      default: lvl = {analog_in.channel, 7'h15};
    endcase
  end
  // storage node tracks the input only while sampling
  always_latch begin
    if (analog_in.sample_en) held = lvl;
  end
  assign comp_out = held >= analog_in.dac_code;
endmodule
`default_nettype wire

/* sim/adc_conversion_sequencer_test.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_sequencer_test
  import acsq_pkg::*;
;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [3:0] be = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic stop = 1'b0;
  logic wt = 1'b0;
  logic [7:0] pins = 8'ha5;
  logic comp;
  logic irq;
  logic wreq;
  logic [31:0] rdo;
  acsq_analog_t ana;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int hi = 0;
  int last_hi = 0;
  logic [23:0] tbl [8] = '{24'h008094, 24'h088096, 24'h00808a, 24'h088002, 24'h0000c9, 24'h000049,
    24'h0080ca, 24'h008048};
  acsq_top DUT (.clk_in(clk_in), .arst_n_in(arst_n_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_byteenable_in(be), .avs_writedata_in(wdat), .avs_readdata_out(rdo),
    .avs_waitrequest_out(wreq), .stop_in(stop), .wait_in(wt), .pin_in(pins), .comp_in(comp),
    .analog_out(ana), .seq_irq_out(irq));
  acsq_analog_model u_ana (.analog_in(ana), .comp_out(comp));
  initial forever #50 clk_in = ~clk_in;
  //////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // cycle count, last sample pulse width since an accepted write, hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (wr && !wreq) hi <= 0;
    else if (ana.sample_en) hi <= hi + 1;
    else if (hi != 0) begin
      last_hi <= hi;
      hi <= 0;
    end
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] i, input logic [15:0] d, output logic [31:0] q);
    @(posedge clk_in);
    adr <= {i, 2'b00};
    rd <= !w;
    wr <= w;
    be <= 4'h3;
    wdat <= {16'h0, d};
    do @(posedge clk_in); while (wreq !== 1'b0);
    q = rdo;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wrr(input logic [3:0] i, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b1, i, d, q);
  endtask
  task automatic rdc(input logic [3:0] i, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    bus(1'b0, i, 16'h0, q);
    chk(q & m, e);
  endtask
  // expected result word from channel choice, reference, width and format
  function automatic logic [15:0] expv(input logic [7:0] c3, input logic [7:0] c4, input logic [7:0] c5, int k);
    logic [2:0] ch;
    logic [9:0] v;
    ch = !c5[4] ? c5[2:0] : c3[3] ? c5[2:0] + k[2:0] : {c5[2], c5[1:0] + k[1:0]};
    v = !c5[6] ? {ch, 7'h15} : c5[1] ? 10'h200 : c5[0] ? 10'h3ff : 10'h000;
    if (!c4[7]) return c5[7] ? {8'h00, v[9:2]} : {v[9:2], 8'h00};
    return c5[7] ? {6'h00, v} : {v, 6'h00};
  endfunction
  // configure, start, poll the sequence flag, check results in order
  task automatic seq(input logic [7:0] c3, input logic [7:0] c4, input logic [7:0] c5);
    logic [31:0] q;
    int n;
    n = c3[3] ? 8 : c5[3] ? 1 : 4;
    wrr(REG_CTL_THREE, {8'h00, c3});
    wrr(REG_CTL_FOUR, {8'h00, c4});
    wrr(REG_CTL_FIVE, {8'h00, c5});
    q = 32'h0;
    for (int p = 0; p < 400 && q[15] !== 1'b1; p++) bus(1'b0, REG_STATUS, 16'h0, q);
    chk(q & 32'hc0ff, 32'h8000 | ((32'h1 << n) - 1));
    for (int k = 0; k < n; k++) rdc(4'(REG_RESULT_BASE + k), {16'h0, expv(c3, c4, c5, k)}, '1);
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    for (int i = 0; i < 16; i++) rdc(4'(i), i == 6 ? {24'h0, pins} : 32'h0, '1);
    wrr(REG_DIG_EN, 16'h000f);
    rdc(REG_DIG_IN, 32'ha0, '1);
    wrr(REG_RESULT_BASE, 16'hffff);
    rdc(REG_RESULT_BASE, 32'h0, '1);
    $display("test map done");
    wrr(REG_CTL_TWO, 16'h0082);
    for (int t = 0; t < 8; t++) begin
      seq(tbl[t][23:16], tbl[t][15:8], tbl[t][7:0]);
      chk({31'h0, irq}, 32'h1);
    end
    $display("test modes done");
    for (int s = 0; s < 4; s++) begin
      seq(8'h00, 8'h80 | 8'(s << 5), 8'h88);
      chk({31'h0, last_hi >= 2 * (6 + (2 << s)) - 2 && last_hi <= 2 * (6 + (2 << s)) + 2}, 32'h1);
    end
    $display("test sample time done");
    // stop, wait with halt, power down, wait without halt
    for (int k = 0; k < 4; k++) begin
      wrr(REG_CTL_TWO, k == 3 ? 16'h0082 : 16'h0086);
      wrr(REG_CTL_FIVE, 16'h00a8);
      stop <= k == 0;
      wt <= k == 1 || k == 3;
      if (k == 2) wrr(REG_CTL_TWO, 16'h0006);
      repeat (100) @(posedge clk_in);
      wrr(REG_STATUS, 16'h80ff);
      repeat (300) @(posedge clk_in);
      rdc(REG_STATUS, k == 3 ? 32'h8001 : 32'h0, k == 3 ? 32'h8001 : 32'hc0ff);
      stop <= 1'b0;
      wt <= 1'b0;
    end
    $display("test halts done");
    seq(8'h00, 8'h80, 8'h88);
    wrr(REG_CTL_TWO, 16'h0080);
    @(posedge clk_in);
    chk({31'h0, irq}, 32'h0);
    wrr(REG_STATUS, 16'h80ff);
    repeat (300) @(posedge clk_in);
    rdc(REG_STATUS, 32'h0, 32'hc0ff);
    wrr(REG_TEST, 16'h0001);
    rdc(REG_CTL_TWO, 32'h80, '1);
    rdc(REG_CTL_FIVE, 32'h0, '1);
    $display("test restart and soft reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
